// ==== hw/adc_cmd_pkg.sv ====
// Summary of operation
// - Opcode 16h starts system offset calibration
// - Opcode 17h starts full-scale calibration
// - Opcode 19h starts internal offset calibration
// - Check mode: op, arg, check, 00h; four replies
// - Read opcode 20h plus index, one register
// - Read data MSB first, third byte, fifth in check mode
// - Unimplemented index reads back 00h
// - Check mode read: six bytes, data check last
// - Write opcode 40h plus index, one register
// - Writing restart registers restarts conversion
// - Host never writes unimplemented indices
// - Opcode F2h blocks all register writes
// - Reads still work while writes blocked
// - Unlocked after reset
// - Opcode F5h allows register writes again
// - Status bit shows lock state
// - Check mismatch sets sticky error flag
package adc_cmd_pkg;
  localparam logic [7:0] OP_SYS_OFFSET_CAL = 8'h16;
  localparam logic [7:0] OP_FULL_SCALE_CAL = 8'h17;
  localparam logic [7:0] OP_INT_OFFSET_CAL = 8'h19;
  localparam logic [7:0] OP_LOCK = 8'hf2;
  localparam logic [7:0] OP_UNLOCK = 8'hf5;
  localparam logic [2:0] OP_READ_BASE = 3'h1;
  localparam logic [2:0] OP_WRITE_BASE = 3'h2;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam int REG_COUNT_DEF = 18;
  localparam logic [4:0] STATUS_IDX = 5'h01;
  localparam logic [4:0] MODE3_IDX = 5'h05;
  localparam int LOCK_BIT = 7;
  localparam int ERR_BIT = 6;
  localparam int CRC_EN_BIT = 5;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [31:0] RESTART_MASK = 32'h0003004c;
  localparam logic [2:0] LEN_PLAIN = 3'h2;
  localparam logic [2:0] LEN_PLAIN_READ = 3'h3;
  localparam logic [2:0] LEN_CHECK = 3'h4;
  localparam logic [2:0] LEN_CHECK_READ = 3'h6;
  localparam int HALF_DEF = 4;
  localparam int EV_SYS = 0;
  localparam int EV_FULL = 1;
  localparam int EV_INT = 2;
  localparam int EV_RESTART = 3;

  function automatic logic [7:0] crc8_next(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction
endpackage

// ==== hw/adc_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic serial_out_ready_pin;
  modport device (input sclk, input cs_n, input din, output serial_out_ready_pin);
  modport host (output sclk, output cs_n, output din, input serial_out_ready_pin);
endinterface
`default_nettype wire

// ==== hw/adc_cmd_device.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_cmd_device #(
  parameter int REG_COUNT = adc_cmd_pkg::REG_COUNT_DEF
) (
  input wire logic clock,
  input wire logic sys_rst,
  adc_link_if.device link,
  output logic system_offset_cal_cmd,
  output logic full_scale_cal_cmd,
  output logic internal_offset_cal_cmd,
  output logic conversion_restart,
  output logic write_locked,
  output logic cal_write_enable,
  output logic check_error_flag
);
  import adc_cmd_pkg::*;

  generate
    if (REG_COUNT > 32 || REG_COUNT <= int'(MODE3_IDX)) begin : g_bad
      $error("REG_COUNT out of range");
    end
  endgenerate

  // Link reset, held by the core clock, asserts the link side asynchronously
  logic link_rst;
  always_ff @(posedge clock) begin
    link_rst <= sys_rst;
  end

  // Frame state, cleared while chip select is high
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [2:0] byte_idx, next_byte_idx;
  logic [6:0] rx, next_rx;
  logic [7:0] tx, next_tx;
  logic [7:0] op, next_op;
  logic [7:0] arg, next_arg;

  // Configuration state
  logic [7:0] regs [REG_COUNT];
  logic [7:0] next_regs [REG_COUNT];
  logic locked, next_locked;
  logic err, next_err;
  logic [3:0] ev_tog, next_ev_tog;

  logic [7:0] byte_in;
  logic last_bit;
  logic crc_on;
  logic is_read;
  logic [7:0] crc_cmd;
  logic [7:0] rd_byte;
  logic [7:0] cmd_op;
  logic [7:0] cmd_arg;
  logic exec;
  logic crc_bad;

  assign byte_in = {rx, link.din};
  assign last_bit = (bit_cnt == 3'h7);
  assign crc_on = regs[MODE3_IDX][CRC_EN_BIT];
  assign is_read = (op[7:5] == OP_READ_BASE);
  assign crc_cmd = crc8_next(crc8_next(CRC_INIT, op), arg);
  assign link.serial_out_ready_pin = tx[7];

  // Register readback, status is live
  always_comb begin
    rd_byte = ZERO_BYTE;
    if (int'(op[4:0]) < REG_COUNT) begin
      rd_byte = regs[op[4:0]];
      if (op[4:0] == STATUS_IDX) begin
        rd_byte = ZERO_BYTE;
        rd_byte[LOCK_BIT] = locked;
        rd_byte[ERR_BIT] = err;
      end
    end
  end

  // Command completes after the argument, or after a good check byte
  always_comb begin
    exec = 1'b0;
    crc_bad = 1'b0;
    cmd_op = op;
    cmd_arg = arg;
    if (last_bit) begin
      if (!crc_on && byte_idx == 3'h1) begin
        exec = 1'b1;
        cmd_arg = byte_in;
      end
      if (crc_on && byte_idx == 3'h2) begin
        exec = (byte_in == crc_cmd);
        crc_bad = (byte_in != crc_cmd);
      end
    end
  end

  always_comb begin
    next_bit_cnt = bit_cnt + 3'h1;
    next_byte_idx = byte_idx;
    next_rx = byte_in[6:0];
    next_tx = {tx[6:0], 1'b1};
    next_op = op;
    next_arg = arg;
    if (last_bit) begin
      if (byte_idx != 3'h7) begin
        next_byte_idx = byte_idx + 3'h1;
      end
      case (byte_idx)
        3'h0: begin
          next_op = byte_in;
          next_tx = byte_in;
        end
        3'h1: begin
          next_arg = byte_in;
          if (crc_on) begin
            next_tx = byte_in;
          end else if (is_read) begin
            next_tx = rd_byte;
          end else begin
            next_tx = ZERO_BYTE;
          end
        end
        3'h2: next_tx = crc_on ? crc_cmd : ZERO_BYTE;
        3'h3: next_tx = (crc_on && is_read) ? rd_byte : ZERO_BYTE;
        3'h4: next_tx = (crc_on && is_read) ? crc8_next(CRC_INIT, rd_byte) : ZERO_BYTE;
        default: next_tx = ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt <= 3'h0;
      byte_idx <= 3'h0;
      rx <= 7'h00;
      tx <= FILL_BYTE;
      op <= ZERO_BYTE;
      arg <= ZERO_BYTE;
    end else begin
      bit_cnt <= next_bit_cnt;
      byte_idx <= next_byte_idx;
      rx <= next_rx;
      tx <= next_tx;
      op <= next_op;
      arg <= next_arg;
    end
  end

  always_comb begin
    next_regs = regs;
    next_locked = locked;
    next_err = err;
    next_ev_tog = ev_tog;
    if (exec) begin
      case (cmd_op)
        OP_SYS_OFFSET_CAL: next_ev_tog[EV_SYS] = ~ev_tog[EV_SYS];
        OP_FULL_SCALE_CAL: next_ev_tog[EV_FULL] = ~ev_tog[EV_FULL];
        OP_INT_OFFSET_CAL: next_ev_tog[EV_INT] = ~ev_tog[EV_INT];
        OP_LOCK: next_locked = 1'b1;
        OP_UNLOCK: next_locked = 1'b0;
        default: begin
          if (cmd_op[7:5] == OP_WRITE_BASE && !locked
              && int'(cmd_op[4:0]) < REG_COUNT) begin
            if (cmd_op[4:0] == STATUS_IDX) begin
              if (!cmd_arg[ERR_BIT]) begin
                next_err = 1'b0;
              end
            end else begin
              next_regs[cmd_op[4:0]] = cmd_arg;
            end
            if (RESTART_MASK[cmd_op[4:0]]) begin
              next_ev_tog[EV_RESTART] = ~ev_tog[EV_RESTART];
            end
          end
        end
      endcase
    end
    if (crc_bad) begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge link.sclk or posedge link_rst) begin
    if (link_rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= REG_RESET;
      end
      locked <= 1'b0;
      err <= 1'b0;
      ev_tog <= 4'h0;
    end else begin
      regs <= next_regs;
      locked <= next_locked;
      err <= next_err;
      ev_tog <= next_ev_tog;
    end
  end

  // Crossing into the core clock: toggles for events, two flops for levels
  logic [3:0] ev_s1, ev_s2, ev_s3;
  logic lock_s1, lock_s2, err_s1, err_s2;
  logic [3:0] pulse, next_pulse;

  always_comb begin
    next_pulse = ev_s2 ^ ev_s3;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ev_s1 <= 4'h0;
      ev_s2 <= 4'h0;
      ev_s3 <= 4'h0;
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
      err_s1 <= 1'b0;
      err_s2 <= 1'b0;
      pulse <= 4'h0;
    end else begin
      ev_s1 <= ev_tog;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
      lock_s1 <= locked;
      lock_s2 <= lock_s1;
      err_s1 <= err;
      err_s2 <= err_s1;
      pulse <= next_pulse;
    end
  end

  assign system_offset_cal_cmd = pulse[EV_SYS];
  assign full_scale_cal_cmd = pulse[EV_FULL];
  assign internal_offset_cal_cmd = pulse[EV_INT];
  assign conversion_restart = pulse[EV_RESTART];
  assign write_locked = lock_s2;
  assign cal_write_enable = ~lock_s2;
  assign check_error_flag = err_s2;
endmodule
`default_nettype wire

// ==== hw/adc_cmd_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_cmd_host #(
  parameter int HALF = adc_cmd_pkg::HALF_DEF
) (
  input wire logic clock,
  input wire logic sys_rst,
  adc_link_if.host link,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic [7:0] cmd_arg,
  input wire logic crc_mode,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_error
);
  import adc_cmd_pkg::*;

  generate
    if (HALF < 2 || HALF > 128) begin : g_bad
      $error("HALF out of range");
    end
  endgenerate

  localparam logic [7:0] HALF_END = 8'(HALF - 1);
  localparam logic [7:0] GAP_END = 8'(2 * HALF - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LOW = 3'h1,
    ST_HIGH = 3'h3,
    ST_GAP = 3'h2
  } host_state_e;

  host_state_e st, next_st;
  logic [7:0] cnt, next_cnt;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [2:0] byte_idx, next_byte_idx;
  logic [2:0] nbytes, next_nbytes;
  logic [7:0] op, next_op;
  logic [7:0] arg, next_arg;
  logic crc_on, next_crc_on;
  logic [7:0] txb, next_txb;
  logic [7:0] rxb, next_rxb;
  logic sclk, next_sclk;
  logic cs_n, next_cs_n;
  logic din, next_din;
  logic [7:0] data, next_data;
  logic bad, next_bad;
  logic next_rsp_valid;
  logic dout_s1, dout_s2;
  logic rd;
  logic [7:0] byte_out;
  logic [2:0] idx_up;

  assign rd = (op[7:5] == OP_READ_BASE);
  assign idx_up = byte_idx + 3'h1;
  assign link.sclk = sclk;
  assign link.cs_n = cs_n;
  assign link.din = din;
  assign cmd_ready = (st == ST_IDLE);

  // Next outgoing byte: arg, then check byte over op and arg (zeros without check mode), then zeros
  always_comb begin
    case (idx_up)
      3'h1: byte_out = arg;
      3'h2: byte_out = crc_on ? crc8_next(crc8_next(CRC_INIT, op), arg) : ZERO_BYTE;
      default: byte_out = ZERO_BYTE;
    endcase
  end

  always_comb begin
    next_st = st;
    next_cnt = cnt + 8'h01;
    next_bit_cnt = bit_cnt;
    next_byte_idx = byte_idx;
    next_nbytes = nbytes;
    next_op = op;
    next_arg = arg;
    next_crc_on = crc_on;
    next_txb = txb;
    next_rxb = rxb;
    next_sclk = sclk;
    next_cs_n = cs_n;
    next_din = din;
    next_data = data;
    next_bad = bad;
    next_rsp_valid = 1'b0;
    case (st)
      ST_IDLE: begin
        next_cnt = 8'h00;
        if (cmd_valid) begin
          next_op = cmd_op;
          next_arg = cmd_arg;
          next_crc_on = crc_mode;
          if (cmd_op[7:5] == OP_READ_BASE) begin
            next_nbytes = crc_mode ? LEN_CHECK_READ : LEN_PLAIN_READ;
          end else begin
            next_nbytes = crc_mode ? LEN_CHECK : LEN_PLAIN;
          end
          next_txb = cmd_op;
          next_din = cmd_op[7];
          next_cs_n = 1'b0;
          next_bit_cnt = 3'h0;
          next_byte_idx = 3'h0;
          next_data = ZERO_BYTE;
          next_bad = 1'b0;
          next_st = ST_LOW;
        end
      end
      ST_LOW: begin
        if (cnt == GAP_END || (cnt == HALF_END && (bit_cnt != 3'h0 || byte_idx != 3'h0))) begin
          next_sclk = 1'b1;
          next_rxb = {rxb[6:0], dout_s2};
          next_cnt = 8'h00;
          next_st = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (cnt == HALF_END) begin
          next_sclk = 1'b0;
          next_cnt = 8'h00;
          if (bit_cnt == 3'h7) begin
            next_bit_cnt = 3'h0;
            if (byte_idx == 3'h1 && rxb != op) begin
              next_bad = 1'b1;
            end
            if (rd && byte_idx == (crc_on ? 3'h4 : 3'h2)) begin
              next_data = rxb;
            end
            if (rd && crc_on && byte_idx == 3'h5 && rxb != crc8_next(CRC_INIT, data)) begin
              next_bad = 1'b1;
            end
            next_byte_idx = idx_up;
            if (idx_up == nbytes) begin
              next_cs_n = 1'b1;
              next_st = ST_GAP;
            end else begin
              next_txb = byte_out;
              next_din = byte_out[7];
              next_st = ST_LOW;
            end
          end else begin
            next_bit_cnt = bit_cnt + 3'h1;
            next_txb = {txb[6:0], 1'b0};
            next_din = txb[6];
            next_st = ST_LOW;
          end
        end
      end
      ST_GAP: begin
        if (cnt == GAP_END) begin
          next_rsp_valid = 1'b1;
          next_st = ST_IDLE;
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= ST_IDLE;
      cnt <= 8'h00;
      bit_cnt <= 3'h0;
      byte_idx <= 3'h0;
      nbytes <= LEN_PLAIN;
      op <= ZERO_BYTE;
      arg <= ZERO_BYTE;
      crc_on <= 1'b0;
      txb <= ZERO_BYTE;
      rxb <= ZERO_BYTE;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      din <= 1'b0;
      data <= ZERO_BYTE;
      bad <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= ZERO_BYTE;
      rsp_error <= 1'b0;
      dout_s1 <= 1'b1;
      dout_s2 <= 1'b1;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      bit_cnt <= next_bit_cnt;
      byte_idx <= next_byte_idx;
      nbytes <= next_nbytes;
      op <= next_op;
      arg <= next_arg;
      crc_on <= next_crc_on;
      txb <= next_txb;
      rxb <= next_rxb;
      sclk <= next_sclk;
      cs_n <= next_cs_n;
      din <= next_din;
      data <= next_data;
      bad <= next_bad;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_valid ? data : rsp_data;
      rsp_error <= next_rsp_valid ? bad : rsp_error;
      dout_s1 <= link.serial_out_ready_pin;
      dout_s2 <= dout_s1;
    end
  end
endmodule
`default_nettype wire

// ==== sim/adc_cmd_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_cmd_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic serial_out_ready_pin
);
  logic sclk_q;
  logic rise;
  logic [5:0] nrise;
  logic [5:0] next_nrise;
  logic [7:0] op_rx;
  logic [7:0] next_op_rx;

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Rises of the link clock within the frame, and the first byte seen on din
  always_comb begin
    rise = sclk && !sclk_q;
    next_nrise = cs_n ? 6'h00 : nrise + {5'h00, rise};
    next_op_rx = (rise && nrise < 6'h08) ? {op_rx[6:0], din} : op_rx;
  end

  always_ff @(posedge clock) begin
    sclk_q <= sclk;
    nrise <= sys_rst ? 6'h00 : next_nrise;
    op_rx <= next_op_rx;
  end

  idle_pin_high_a: assert property (cs_n |-> serial_out_ready_pin)
    else $error("data out not high while deselected");
  idle_sclk_low_a: assert property (cs_n |-> !sclk)
    else $error("link clock not low while deselected");
  cs_setup_a: assert property ($fell(cs_n) |-> (!sclk) [*3] ##[1:2] sclk)
    else $error("first link clock rise out of place");
  sclk_high_a: assert property ($rose(sclk) |=> sclk ##1 !sclk)
    else $error("link clock high phase wrong");
  din_hold_a: assert property (sclk && $past(sclk) |-> $stable(din))
    else $error("data in moved while link clock high");
  pin_moves_a: assert property (!cs_n && $past(!cs_n) && $changed(serial_out_ready_pin)
    |-> $rose(sclk))
    else $error("data out moved away from a link clock rise");
  fill_byte_a: assert property (!cs_n && $fell(sclk) && nrise < 6'h08
    |-> serial_out_ready_pin)
    else $error("first reply byte not all ones");
  echo_op_a: assert property (!cs_n && $fell(sclk) && nrise >= 6'h08 && nrise < 6'h10
    |-> serial_out_ready_pin == op_rx[3'(6'h0f - nrise)])
    else $error("second reply byte not the opcode echo");
  frame_len_a: assert property ($rose(cs_n) |-> nrise inside {6'h10, 6'h18, 6'h20, 6'h30})
    else $error("frame length not a whole command");

  cover property ($rose(cs_n) && nrise == 6'h10);
  cover property ($rose(cs_n) && nrise == 6'h18);
  cover property ($rose(cs_n) && nrise == 6'h20);
  cover property ($rose(cs_n) && nrise == 6'h30);
endmodule
`default_nettype wire

// ==== sim/tb_adc_cal_reg_lock_cmds.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_adc_cal_reg_lock_cmds;
  import adc_cmd_pkg::*;
  typedef struct {
    logic [7:0] op;
    logic [7:0] arg;
    logic crc;
    logic [7:0] data;
    logic [3:0] ev;
    logic lk;
  } row_s;
  logic clock, sys_rst, cmd_valid, crc_mode, cmd_ready, rsp_valid, rsp_error;
  logic [7:0] cmd_op, cmd_arg, rsp_data;
  logic sys_cal, full_cal, int_cal, restart, write_locked, cal_write_enable, b_err;
  logic [3:0] ev = 4'h0;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Event bits: restart, internal, full scale, system
  row_s rows [21] = '{
    '{8'h21, 8'h00, 1'b0, 8'h00, 4'h0, 1'b0},
    '{8'h16, 8'h00, 1'b0, 8'h00, 4'h1, 1'b0},
    '{8'h17, 8'h5a, 1'b0, 8'h00, 4'h2, 1'b0},
    '{8'h19, 8'hff, 1'b0, 8'h00, 4'h4, 1'b0},
    '{8'h42, 8'ha5, 1'b0, 8'h00, 4'h8, 1'b0},
    '{8'h22, 8'h00, 1'b0, 8'ha5, 4'h0, 1'b0},
    '{8'h44, 8'h3c, 1'b0, 8'h00, 4'h0, 1'b0},
    '{8'h24, 8'h00, 1'b0, 8'h3c, 4'h0, 1'b0},
    '{8'h3f, 8'h00, 1'b0, 8'h00, 4'h0, 1'b0},
    '{8'hf2, 8'h00, 1'b0, 8'h00, 4'h0, 1'b1},
    '{8'h42, 8'h11, 1'b0, 8'h00, 4'h0, 1'b1},
    '{8'h22, 8'h00, 1'b0, 8'ha5, 4'h0, 1'b1},
    '{8'h21, 8'h00, 1'b0, 8'h80, 4'h0, 1'b1},
    '{8'h16, 8'h00, 1'b0, 8'h00, 4'h1, 1'b1},
    '{8'hf5, 8'h00, 1'b0, 8'h00, 4'h0, 1'b0},
    '{8'h42, 8'h11, 1'b0, 8'h00, 4'h8, 1'b0},
    '{8'h45, 8'h20, 1'b0, 8'h00, 4'h0, 1'b0},
    '{8'h22, 8'h00, 1'b1, 8'h11, 4'h0, 1'b0},
    '{8'h17, 8'h00, 1'b1, 8'h00, 4'h2, 1'b0},
    '{8'h43, 8'h07, 1'b1, 8'h00, 4'h8, 1'b0},
    '{8'h23, 8'h00, 1'b1, 8'h07, 4'h0, 1'b0}
  };

  adc_link_if link();
  adc_link_if bl();

  adc_cmd_host #(.HALF(2)) i_adc_cmd_host (.clock(clock), .sys_rst(sys_rst), .link(link),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg(cmd_arg), .crc_mode(crc_mode),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error));
  adc_cmd_device i_adc_cmd_device (.clock(clock), .sys_rst(sys_rst), .link(link),
    .system_offset_cal_cmd(sys_cal), .full_scale_cal_cmd(full_cal),
    .internal_offset_cal_cmd(int_cal), .conversion_restart(restart),
    .write_locked(write_locked), .cal_write_enable(cal_write_enable), .check_error_flag());
  adc_cmd_device i_adc_cmd_device_b (.clock(clock), .sys_rst(sys_rst), .link(bl),
    .system_offset_cal_cmd(), .full_scale_cal_cmd(), .internal_offset_cal_cmd(),
    .conversion_restart(), .write_locked(), .cal_write_enable(), .check_error_flag(b_err));
  adc_cmd_props i_adc_cmd_props (.clock(clock), .sys_rst(sys_rst), .sclk(link.sclk),
    .cs_n(link.cs_n), .din(link.din), .serial_out_ready_pin(link.serial_out_ready_pin));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) ev <= ev | {restart, int_cal, full_cal, sys_cal};

  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One command through the host, then its reply and the device side effects
  task run(input row_s r);
    int k;
    while (cmd_ready !== 1'b1) begin
      @(posedge clock);
      #1;
    end
    cmd_op = r.op;
    cmd_arg = r.arg;
    crc_mode = r.crc;
    cmd_valid = 1'b1;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    ev = 4'h0;
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (rsp_valid !== 1'b1 && k < 600);
    chk("rsp_valid", {7'h00, rsp_valid}, 8'h01);
    chk("rsp_data", rsp_data, r.data);
    chk("rsp_error", {7'h00, rsp_error}, 8'h00);
    repeat (8) @(posedge clock);
    #1;
    chk("events", {4'h0, ev}, {4'h0, r.ev});
    chk("write_locked", {7'h00, write_locked}, {7'h00, r.lk});
    chk("cal_write_enable", {7'h00, cal_write_enable}, {7'h00, ~r.lk});
  endtask

  // Raw frame on the second link, n bits from the top of w
  task bb_frame(input logic [31:0] w, input int n);
    bl.cs_n = 1'b0;
    for (int i = 31; i > 31 - n; i--) begin
      bl.din = w[i];
      repeat (2) @(posedge clock);
      #1;
      bl.sclk = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      bl.sclk = 1'b0;
    end
    repeat (2) @(posedge clock);
    #1;
    bl.cs_n = 1'b1;
    repeat (4) @(posedge clock);
    #1;
  endtask

  initial begin
    cmd_valid = 1'b0;
    cmd_op = 8'h00;
    cmd_arg = 8'h00;
    crc_mode = 1'b0;
    sys_rst = 1'b1;
    bl.sclk = 1'b0;
    bl.cs_n = 1'b1;
    bl.din = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    chk("write_locked", {7'h00, write_locked}, 8'h00);
    chk("cal_write_enable", {7'h00, cal_write_enable}, 8'h01);
    for (int i = 0; i < 21; i++) run(rows[i]);
    // Reset in mid-run while locked
    run('{8'hf2, 8'h00, 1'b1, 8'h00, 4'h0, 1'b1});
    sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    chk("write_locked", {7'h00, write_locked}, 8'h00);
    chk("cal_write_enable", {7'h00, cal_write_enable}, 8'h01);
    run('{8'h22, 8'h00, 1'b0, 8'h00, 4'h0, 1'b0});
    // Second device: check mode on, then a frame with a wrong check byte
    bb_frame({8'h45, 8'h20, 16'h0000}, 16);
    bb_frame({8'h16, 8'h00, 8'h00, 8'h00}, 32);
    repeat (8) @(posedge clock);
    #1;
    chk("check_error_flag", {7'h00, b_err}, 8'h01);
    repeat (40) @(posedge clock);
    #1;
    chk("check_error_flag", {7'h00, b_err}, 8'h01);
    // Host clears the flag by a checked write of status with bit 6 low
    bb_frame({8'h41, 8'h00, 8'h4e, 8'h00}, 32);
    repeat (8) @(posedge clock);
    #1;
    chk("check_error_flag", {7'h00, b_err}, 8'h00);
    tally_and_finish();
  end

  initial begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
